//--- src/iosc_regs.sv
// Register slice: SCL low time, I/O supply control, GPIO levels.
// Assumes a byte register port from the serial control bus logic,
// single-cycle write strobe and registered read data.
//
// Functional notes
// - SCL low field, reset 0x7a, sets master SCL low width.
// - As slave over control channel, hold SDA valid low-time first.
// - Low duration is count plus four oscillator periods of 40 ns.
// - Voltage select: 0 is 1.8 V, 1 is 3.3 V; reads detected level.
// - Override clear uses detected level; set uses written values.
// - Supply mode 00 is 1.8 V, 11 is 3.3 V; reads detected level.
// - Read-only nibble gives the four GPIO pin levels.
`timescale 1ns/1ps
module iosc_regs (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Register port
    input  wire logic [7:0] regAddr,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWdata,
    output logic [7:0]      regRdata,
    // Device status inputs
    input  wire logic       detected3p3,
    input  wire logic [3:0] gpioPins,
    // SCL low phase requests
    input  wire logic       masterLowStart,
    input  wire logic       slaveLowStart,
    // Timing outputs
    output logic            sclLowDone,
    output logic            slaveSclRelease,
    output logic [7:0]      sclLowCount,
    // Supply controls
    output logic            ioVoltageSelect,
    output logic [1:0]      ioSupplyMode,
    output logic [3:0]      gpioInputEnable
);
    logic [7:0] sclLow;
    logic [7:0] next_sclLow;
    logic [7:0] rsvdByte;
    logic [7:0] next_rsvdByte;
    logic [7:0] ioCtl;
    logic [7:0] next_ioCtl;
    logic [3:0] pinRsvd;
    logic [3:0] next_pinRsvd;
    logic [7:0] gpioIn;
    logic [7:0] next_gpioIn;
    logic [7:0] next_regRdata;
    logic       next_ioVoltageSelect;
    logic [1:0] next_ioSupplyMode;
    logic [2:0] oscCount;
    logic [2:0] next_oscCount;
    logic       oscTick;
    logic       timerDone;
    logic       slaveActive;
    logic       next_slaveActive;
    logic       next_sclLowDone;
    logic       next_slaveSclRelease;
    logic [1:0] detectedMode;

    assign detectedMode = detected3p3 ? iosc_pkg::MODE_3P3
                                      : iosc_pkg::MODE_1P8;

    // Register writes, decoded by address
    always_comb begin
        next_sclLow   = sclLow;
        next_rsvdByte = rsvdByte;
        next_ioCtl    = ioCtl;
        next_pinRsvd  = pinRsvd;
        next_gpioIn   = gpioIn;
        if (regWrite) begin
            if (regAddr == iosc_pkg::ADDR_SCL_LOW) begin
                next_sclLow = regWdata;
            end else if (regAddr == iosc_pkg::ADDR_RESERVED) begin
                next_rsvdByte = regWdata;
            end else if (regAddr == iosc_pkg::ADDR_IO_VOLTAGE_CONTROL) begin
                next_ioCtl = regWdata;
            end else if (regAddr == iosc_pkg::ADDR_PIN_LEVELS) begin
                next_pinRsvd = regWdata[7:4]; // Low nibble is read-only
            end else if (regAddr == iosc_pkg::ADDR_GPIO_IN) begin
                next_gpioIn = regWdata;
            end
        end
    end

    // Effective supply controls follow detection unless overridden
    always_comb begin
        if (ioCtl[iosc_pkg::BIT_OV]) begin
            next_ioVoltageSelect = ioCtl[iosc_pkg::BIT_SEL];
            next_ioSupplyMode    = ioCtl[iosc_pkg::MODE_HI:
                                         iosc_pkg::MODE_LO];
        end else begin
            next_ioVoltageSelect = detected3p3;
            next_ioSupplyMode    = detectedMode;
        end
    end

    // Read mux; fields under detection show the live level
    always_comb begin
        next_regRdata = regRdata;
        if (regRead) begin
            if (regAddr == iosc_pkg::ADDR_SCL_LOW) begin
                next_regRdata = sclLow;
            end else if (regAddr == iosc_pkg::ADDR_RESERVED) begin
                next_regRdata = rsvdByte;
            end else if (regAddr == iosc_pkg::ADDR_IO_VOLTAGE_CONTROL) begin
                next_regRdata = ioCtl;
                if (!ioCtl[iosc_pkg::BIT_OV]) begin
                    next_regRdata[iosc_pkg::BIT_SEL] = detected3p3;
                    next_regRdata[iosc_pkg::MODE_HI:iosc_pkg::MODE_LO] =
                        detectedMode;
                end
            end else if (regAddr == iosc_pkg::ADDR_PIN_LEVELS) begin
                next_regRdata = {pinRsvd, gpioPins};
            end else if (regAddr == iosc_pkg::ADDR_GPIO_IN) begin
                next_regRdata = gpioIn;
            end else begin
                next_regRdata = 8'h00; // Unmapped reads as zero
            end
        end
    end

    // Oscillator-period tick from the 200 MHz clock
    always_comb begin
        oscTick       = (oscCount == 3'(iosc_pkg::OSC_DIV - 1));
        next_oscCount = oscTick ? 3'h0 : oscCount + 3'h1;
    end

    // Slave phase tracks which kind of low phase is running
    always_comb begin
        next_slaveActive     = slaveActive;
        next_sclLowDone      = 1'b0;
        next_slaveSclRelease = 1'b0;
        if (masterLowStart || slaveLowStart) begin
            next_slaveActive = slaveLowStart;
        end else if (timerDone) begin
            next_slaveActive     = 1'b0;
            next_sclLowDone      = !slaveActive;
            next_slaveSclRelease = slaveActive;
        end
    end

    iosc_low_timer u_timer (
        .clk      (clk),
        .srst     (srst),
        .start    (masterLowStart || slaveLowStart),
        .tick     (oscTick),
        .lowCount (sclLow),
        .busy     (),
        .done     (timerDone)
    );

    // State registers
    always_ff @(posedge clk) begin
        if (srst) begin
            sclLow          <= iosc_pkg::RST_SCL_LOW;
            rsvdByte        <= iosc_pkg::RST_RESERVED;
            ioCtl           <= iosc_pkg::RST_IO_VOLTAGE_CONTROL;
            pinRsvd         <= iosc_pkg::RST_PIN_HIGH;
            gpioIn          <= {iosc_pkg::RST_GPIO_IN_HI,
                                iosc_pkg::RST_GPIO_IN_LO};
            regRdata        <= 8'h00;
            ioVoltageSelect <= 1'b0;
            ioSupplyMode    <= iosc_pkg::MODE_1P8;
            oscCount        <= 3'h0;
            slaveActive     <= 1'b0;
            sclLowDone      <= 1'b0;
            slaveSclRelease <= 1'b0;
            sclLowCount     <= iosc_pkg::RST_SCL_LOW;
            gpioInputEnable <= iosc_pkg::RST_GPIO_IN_LO;
        end else begin
            sclLow          <= next_sclLow;
            rsvdByte        <= next_rsvdByte;
            ioCtl           <= next_ioCtl;
            pinRsvd         <= next_pinRsvd;
            gpioIn          <= next_gpioIn;
            regRdata        <= next_regRdata;
            ioVoltageSelect <= next_ioVoltageSelect;
            ioSupplyMode    <= next_ioSupplyMode;
            oscCount        <= next_oscCount;
            slaveActive     <= next_slaveActive;
            sclLowDone      <= next_sclLowDone;
            slaveSclRelease <= next_slaveSclRelease;
            sclLowCount     <= next_sclLow;
            gpioInputEnable <= next_gpioIn[3:0];
        end
    end
endmodule // iosc_regs

//--- src/iosc_pkg.sv
// Constants for the I/O and SCL timing register slice.
// Assumes byte-wide register access at printed offsets.
package iosc_pkg;
    // Register offsets
    localparam logic [7:0] ADDR_SCL_LOW    = 8'h0b;
    localparam logic [7:0] ADDR_RESERVED   = 8'h0c;
    localparam logic [7:0] ADDR_IO_VOLTAGE_CONTROL     = 8'h0d;
    localparam logic [7:0] ADDR_PIN_LEVELS = 8'h0e;
    localparam logic [7:0] ADDR_GPIO_IN    = 8'h0f;
    // Reset values
    localparam logic [7:0] RST_SCL_LOW     = 8'h7a;
    localparam logic [7:0] RST_RESERVED    = 8'h00;
    localparam logic [7:0] RST_IO_VOLTAGE_CONTROL      = 8'h09;
    localparam logic [3:0] RST_PIN_HIGH    = 4'h0;
    localparam logic [3:0] RST_GPIO_IN_HI  = 4'h7;
    localparam logic [3:0] RST_GPIO_IN_LO  = 4'hf;
    // Field positions in the I/O control register
    localparam int BIT_SEL     = 7;
    localparam int BIT_OV      = 6;
    localparam int MODE_HI     = 5;
    localparam int MODE_LO     = 4;
    // Supply mode encodings
    localparam logic [1:0] MODE_1P8 = 2'h0;
    localparam logic [1:0] MODE_3P3 = 2'h3;
    // Fixed extra oscillator periods in each SCL low phase
    localparam logic [8:0] SCL_EXTRA = 9'h004;
    // Oscillator timing: nominal period and our clock rate
    localparam int OSC_PERIOD_NS = 40;
    localparam int CLK_PERIOD_NS = 5;
    localparam int OSC_DIV = OSC_PERIOD_NS / CLK_PERIOD_NS;
endpackage

//--- src/iosc_low_timer.sv
// Counts one SCL low phase: programmed count plus extra periods.
// Assumes a single clock; tick marks one oscillator period.
`timescale 1ns/1ps
module iosc_low_timer (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       srst,
    // Control
    input  wire logic       start,
    input  wire logic       tick,
    input  wire logic [7:0] lowCount,
    // Status
    output logic            busy,
    output logic            done
);
    logic [8:0] remain;
    logic [8:0] next_remain;
    logic       next_busy;
    logic       next_done;

    // Load on start, count down per oscillator tick
    always_comb begin
        next_remain = remain;
        next_busy   = busy;
        next_done   = 1'b0;
        if (start) begin
            next_remain = {1'b0, lowCount} + iosc_pkg::SCL_EXTRA;
            next_busy   = 1'b1;
        end else if (busy && tick) begin
            if (remain <= 9'h001) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
            next_remain = remain - 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            remain <= 9'h000;
            busy   <= 1'b0;
            done   <= 1'b0;
        end else begin
            remain <= next_remain;
            busy   <= next_busy;
            done   <= next_done;
        end
    end
endmodule // iosc_low_timer

//--- sim/iosc_regs_asserts.sv
// Checker for the register slice ports.
// Bound to iosc_regs from the bench top file.
`timescale 1ns/1ps
module iosc_regs_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       srst,
    // Register port
    input wire logic [7:0] regAddr,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    // Status and timing
    input wire logic       detected3p3,
    input wire logic [3:0] gpioPins,
    input wire logic       masterLowStart,
    input wire logic       slaveLowStart,
    input wire logic       sclLowDone,
    input wire logic       slaveSclRelease,
    input wire logic [7:0] sclLowCount,
    input wire logic       ioVoltageSelect,
    input wire logic [1:0] ioSupplyMode
);
    logic [11:0] cnt, next_cnt, win;
    logic [7:0]  lat, next_lat;
    logic        ov, next_ov, sel, next_sel, wrCtl;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Nominal low phase in clocks; window allows tick phase slack
    assign win = ({4'h0, lat} + 12'h004) << 3;
    assign wrCtl = regWrite && regAddr == iosc_pkg::ADDR_IO_VOLTAGE_CONTROL;
    // Cycles since last start, shadow of override and select
    always_comb begin
        next_cnt = cnt + 12'h001;
        next_lat = lat;
        next_ov  = wrCtl ? regWdata[6] : ov;
        next_sel = wrCtl ? regWdata[7] : sel;
        if (masterLowStart || slaveLowStart) begin
            next_cnt = 12'h001;
            next_lat = sclLowCount;
        end
        if (srst) begin
            next_ov  = 1'b0;
            next_sel = 1'b0;
        end
    end
    always_ff @(posedge clk) begin
        cnt <= next_cnt;
        lat <= next_lat;
        ov  <= next_ov;
        sel <= next_sel;
    end
    count_follow_a: assert property (regWrite && regAddr ==
        iosc_pkg::ADDR_SCL_LOW |-> ##2 sclLowCount == $past(regWdata, 2))
        else $error("low count not updated");
    rst_count_a: assert property ($fell(srst) |->
        sclLowCount == iosc_pkg::RST_SCL_LOW) else $error("bad reset count");
    master_window_a: assert property (sclLowDone |->
        cnt + 12'h007 >= win && cnt <= win + 12'h00a)
        else $error("master low phase length wrong");
    slave_window_a: assert property (slaveSclRelease |->
        cnt + 12'h007 >= win && cnt <= win + 12'h00a)
        else $error("slave setup length wrong");
    auto_level_a: assert property ((!ov && $stable(detected3p3))[*3]
        |-> ioVoltageSelect == detected3p3) else $error("not detected");
    ov_write_a: assert property ((ov && $stable(sel))[*3] |->
        ioVoltageSelect == sel) else $error("override ignored");
    // Under override the mode field may differ from select, so only
    // check once detection has driven both for a full cycle
    mode_match_a: assert property ((!ov)[*2] |->
        ioSupplyMode == {2{ioVoltageSelect}})
        else $error("mode encoding wrong");
    pin_read_a: assert property (regRead && regAddr ==
        iosc_pkg::ADDR_PIN_LEVELS |=> regRdata[3:0] == $past(gpioPins))
        else $error("pin levels wrong");
    cover property (sclLowDone);
    cover property (slaveSclRelease);
    cover property (ov && ioVoltageSelect);
endmodule // iosc_regs_asserts

//--- sim/iosc_regs_bench.sv
// Bench for the register slice: reads, writes, supply and timers.
// Drives inputs on falling edges; the checker is bound at the foot.
`timescale 1ns/1ps
module iosc_regs_bench;
    logic       clk, srst, regWrite, regRead, detected3p3, rdSeen;
    logic       masterLowStart, slaveLowStart, sclLowDone;
    logic       slaveSclRelease, ioVoltageSelect;
    logic [7:0] regAddr, regWdata, regRdata, sclLowCount, v;
    logic [3:0] gpioPins, gpioInputEnable;
    logic [1:0] ioSupplyMode;
    logic [7:0] expQ[$];
    int         num_errors, checks, seed, i;
    iosc_regs dut (.clk(clk), .srst(srst), .regAddr(regAddr),
        .regWrite(regWrite), .regRead(regRead), .regWdata(regWdata),
        .regRdata(regRdata), .detected3p3(detected3p3),
        .gpioPins(gpioPins), .masterLowStart(masterLowStart),
        .slaveLowStart(slaveLowStart), .sclLowDone(sclLowDone),
        .slaveSclRelease(slaveSclRelease), .sclLowCount(sclLowCount),
        .ioVoltageSelect(ioVoltageSelect), .ioSupplyMode(ioSupplyMode),
        .gpioInputEnable(gpioInputEnable));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks=%0d errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        regAddr = a;
        regWdata = d;
        regWrite = 1'b1;
        @(negedge clk);
        regWrite = 1'b0;
    endtask
    // Idle cycle after each read keeps strobes single-assigned
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        regAddr = a;
        regRead = 1'b1;
        expQ.push_back(e);
        @(negedge clk);
        regRead = 1'b0;
    endtask
    task supply(input logic s);
        repeat (3) @(negedge clk);
        check({7'h0, ioVoltageSelect}, {7'h0, s});
        check({6'h0, ioSupplyMode}, {6'h0, s, s});
    endtask
    // Bounded wait for the end of one low phase
    task timed(input logic slave, input logic [7:0] c);
        logic got;
        wr(iosc_pkg::ADDR_SCL_LOW, c);
        @(negedge clk);
        masterLowStart = !slave;
        slaveLowStart = slave;
        @(negedge clk);
        masterLowStart = 1'b0;
        slaveLowStart = 1'b0;
        got = 1'b0;
        for (int k = 0; k < 4000 && !got; k++) begin
            @(negedge clk);
            got = slave ? slaveSclRelease : sclLowDone;
        end
        check({7'h0, got}, 8'h01);
        if (!got) print_verdict;
    endtask
    // Read data lands one cycle after the read edge
    always @(posedge clk) rdSeen <= regRead && !srst;
    always @(negedge clk) begin
        if (rdSeen) check(regRdata, expQ.pop_front());
    end
    initial begin
        {srst, regWrite, regRead, masterLowStart, slaveLowStart} = 5'h10;
        {regAddr, regWdata, gpioPins, detected3p3} = 21'h0;
        {num_errors, checks, seed} = {32'h0, 32'h0, 32'hbeb0};
        repeat (20) @(negedge clk);
        srst = 1'b0;
        rd(iosc_pkg::ADDR_SCL_LOW, iosc_pkg::RST_SCL_LOW);
        rd(iosc_pkg::ADDR_RESERVED, 8'h00);
        rd(iosc_pkg::ADDR_IO_VOLTAGE_CONTROL, 8'h09);
        rd(iosc_pkg::ADDR_GPIO_IN, 8'h7f);
        rd(8'h10, 8'h00);
        check({4'h0, gpioInputEnable}, {4'h0, iosc_pkg::RST_GPIO_IN_LO});
        v = 8'($random(seed));
        wr(iosc_pkg::ADDR_SCL_LOW, v);
        rd(iosc_pkg::ADDR_SCL_LOW, v);
        check(sclLowCount, v);
        // Input enables follow the low nibble of the written byte
        wr(iosc_pkg::ADDR_GPIO_IN, v);
        check({4'h0, gpioInputEnable}, {4'h0, v[3:0]});
        rd(iosc_pkg::ADDR_GPIO_IN, v);
        $display("registers test done");
        detected3p3 = 1'b1;
        supply(1'b1);
        rd(iosc_pkg::ADDR_IO_VOLTAGE_CONTROL, 8'hb9);
        detected3p3 = 1'b0;
        wr(iosc_pkg::ADDR_IO_VOLTAGE_CONTROL, 8'hf9);
        supply(1'b1);
        rd(iosc_pkg::ADDR_IO_VOLTAGE_CONTROL, 8'hf9);
        wr(iosc_pkg::ADDR_IO_VOLTAGE_CONTROL, 8'h49);
        supply(1'b0);
        wr(iosc_pkg::ADDR_IO_VOLTAGE_CONTROL, 8'h09);
        detected3p3 = 1'b1;
        supply(1'b1);
        $display("supply test done");
        wr(iosc_pkg::ADDR_PIN_LEVELS, 8'ha5);
        for (i = 0; i < 8; i++) begin
            v = 8'($random(seed));
            gpioPins = v[3:0];
            rd(iosc_pkg::ADDR_PIN_LEVELS, {4'ha, v[3:0]});
        end
        $display("pin level test done");
        timed(1'b0, 8'h00);
        timed(1'b1, 8'h03);
        $display("timer test done");
        repeat (4) @(negedge clk);
        print_verdict;
    end
endmodule // iosc_regs_bench
bind iosc_regs iosc_regs_asserts chk (.clk(clk), .srst(srst),
    .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
    .regWdata(regWdata), .regRdata(regRdata),
    .detected3p3(detected3p3), .gpioPins(gpioPins),
    .masterLowStart(masterLowStart), .slaveLowStart(slaveLowStart),
    .sclLowDone(sclLowDone), .slaveSclRelease(slaveSclRelease),
    .sclLowCount(sclLowCount), .ioVoltageSelect(ioVoltageSelect),
    .ioSupplyMode(ioSupplyMode));
